// ==== logic/lsr_status_bank.sv ====
// Top: four framers' latched status, masks, summary and shared interrupt
`timescale 1ns/100ps
`default_nettype none
// Function
// - A status bit sets whenever its event occurs or condition persists.
// - Event and info bits stay set until a host mask write of ones clears them.
// - Once cleared, a bit sets again only on recurrence or persistence.
// - Mask-write ones copy the latched value to readback, then clear it.
// - Mask-write zeros keep readback copy and leave latched bit alone.
// - Sync search status is read-only, real time, never latched.
// - Only event registers drive a single shared active-low interrupt.
// - Each event bit is gated by its matching interrupt mask bit.
// - Summary holds one bit per framer and event register, framer 0 lowest.
// - Info bits 7 and 4 set when elastic store fills, frame deleted.
module lsr_status_bank
  import lsr_pkg::*;
#(
  parameter int FRAMERS = lsr_pkg::NUM_FRAMERS
)
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Parallel control port, framer select and register address
  input wire logic [1:0] FRAMER_SEL_I,
  input wire logic [4:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  // Per-framer event sources, one-cycle or level
  input wire logic [FRAMERS*8-1:0] EVENT_A_I,
  input wire logic [FRAMERS*8-1:0] EVENT_B_I,
  input wire logic [FRAMERS*8-1:0] INFO_EVENT_I,
  input wire logic [FRAMERS*8-1:0] SYNC_STATE_I,
  input wire logic [FRAMERS-1:0] RCLK_PIN_I,
  input wire logic [FRAMERS-1:0] CRC_WORD_I,
  input wire logic [FRAMERS-1:0] CRC_BAD_I,
  input wire logic [FRAMERS-1:0] FAS_WORD_I,
  input wire logic [FRAMERS-1:0] FAS_BAD_I,
  input wire logic [FRAMERS-1:0] MF_WORD_I,
  input wire logic [FRAMERS-1:0] MF_BAD_I,
  // Shared interrupt
  output logic INT_N_O
);
  // ==========================================================
  // Per-framer logic
  logic [7:0] rd_a [FRAMERS];
  logic [7:0] rd_b [FRAMERS];
  logic [7:0] rd_info [FRAMERS];
  logic [7:0] mask_a_q [FRAMERS];
  logic [7:0] mask_a_d [FRAMERS];
  logic [7:0] mask_b_q [FRAMERS];
  logic [7:0] mask_b_d [FRAMERS];
  logic [2*FRAMERS-1:0] summary;
  logic [FRAMERS-1:0] rclk_s1_q, rclk_s2_q, rclk_s3_q, rclk_s_q;

  // Receive clock pin is asynchronous: three flops, accept on agreement
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rclk_s1_q <= '0;
      rclk_s2_q <= '0;
      rclk_s3_q <= '0;
      rclk_s_q <= '0;
    end
    else
    begin
      rclk_s1_q <= RCLK_PIN_I;
      rclk_s2_q <= rclk_s1_q;
      rclk_s3_q <= rclk_s2_q;
      rclk_s_q <= (rclk_s2_q & rclk_s3_q) |
                  (rclk_s_q & (rclk_s2_q | rclk_s3_q));
    end
  end

  for (genvar f = 0; f < FRAMERS; f++)
  begin : g_framer
    logic sel;
    logic [2:0] wsel;
    assign sel = (FRAMER_SEL_I == 2'(f));
    assign wsel = {ADDR_I == ADDR_RECEIVE_INFO,
                   ADDR_I == ADDR_EVENT_STATUS_B,
                   ADDR_I == ADDR_EVENT_STATUS_A};

    always_comb
    begin
      mask_a_d[f] = mask_a_q[f];
      mask_b_d[f] = mask_b_q[f];
      if (WR_I && sel && ADDR_I == ADDR_EVENT_MASK_A)
        mask_a_d[f] = WDATA_I;
      if (WR_I && sel && ADDR_I == ADDR_EVENT_MASK_B)
        mask_b_d[f] = WDATA_I;
    end
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
      if (!RSTN_I)
      begin
        mask_a_q[f] <= MASK_RESET;
        mask_b_q[f] <= MASK_RESET;
      end
      else
      begin
        mask_a_q[f] <= mask_a_d[f];
        mask_b_q[f] <= mask_b_d[f];
      end
    end

    lsr_framer_status u_status (
      .clk_i(REF_CLK_I),
      .rstn_i(RSTN_I),
      .ev_a_i(EVENT_A_I[f*8 +: 8]),
      .ev_b_i(EVENT_B_I[f*8 +: 8]),
      .info_raw_i(INFO_EVENT_I[f*8 +: 8]),
      .rclk_sync_i(rclk_s_q[f]),
      .crc_word_i(CRC_WORD_I[f]),
      .crc_bad_i(CRC_BAD_I[f]),
      .fas_word_i(FAS_WORD_I[f]),
      .fas_bad_i(FAS_BAD_I[f]),
      .mf_word_i(MF_WORD_I[f]),
      .mf_bad_i(MF_BAD_I[f]),
      .wr_i(WR_I && sel),
      .wr_sel_i(wsel),
      .wr_data_i(WDATA_I),
      .mask_a_i(mask_a_q[f]),
      .mask_b_i(mask_b_q[f]),
      .read_a_o(rd_a[f]),
      .read_b_o(rd_b[f]),
      .read_info_o(rd_info[f]),
      .irq_a_o(summary[2*f]),
      .irq_b_o(summary[2*f+1])
    );
  end

  // ==========================================================
  // Read path, registered; unmapped addresses read zero
  logic [7:0] rdata_q, rdata_d;
  logic int_n_q;

  always_comb
  begin
    rdata_d = rdata_q;
    if (RD_I)
    begin
      case (ADDR_I)
        ADDR_EVENT_STATUS_A: rdata_d = rd_a[FRAMER_SEL_I];
        ADDR_EVENT_STATUS_B: rdata_d = rd_b[FRAMER_SEL_I];
        ADDR_RECEIVE_INFO: rdata_d = rd_info[FRAMER_SEL_I];
        ADDR_EVENT_MASK_A: rdata_d = mask_a_q[FRAMER_SEL_I];
        ADDR_EVENT_MASK_B: rdata_d = mask_b_q[FRAMER_SEL_I];
        ADDR_SYNC_SEARCH:
          rdata_d = SYNC_STATE_I[FRAMER_SEL_I*8 +: 8];
        ADDR_IRQ_SUMMARY: rdata_d = 8'(summary);
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rdata_q <= 8'h00;
      int_n_q <= 1'b1;
    end
    else
    begin
      rdata_q <= rdata_d;
      int_n_q <= ~(|summary);
    end
  end

  assign RDATA_O = rdata_q;
  assign INT_N_O = int_n_q;
endmodule : lsr_status_bank
`default_nettype wire

// ==== logic/lsr_pkg.sv ====
// Package: register offsets, field positions and sizes for the status bank
package lsr_pkg;
  localparam int NUM_FRAMERS = 4;
  localparam logic [4:0] ADDR_EVENT_STATUS_A = 5'h06;
  localparam logic [4:0] ADDR_EVENT_STATUS_B = 5'h07;
  localparam logic [4:0] ADDR_RECEIVE_INFO = 5'h08;
  localparam logic [4:0] ADDR_EVENT_MASK_A = 5'h16;
  localparam logic [4:0] ADDR_EVENT_MASK_B = 5'h17;
  localparam logic [4:0] ADDR_SYNC_SEARCH = 5'h1e;
  localparam logic [4:0] ADDR_IRQ_SUMMARY = 5'h1f;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int BIT_TX_SLIP_FULL = 7;
  localparam int BIT_TX_SLIP_EMPTY = 6;
  localparam int BIT_RX_CLOCK_LOST = 5;
  localparam int BIT_RX_SLIP_FULL = 4;
  localparam int BIT_RX_SLIP_EMPTY = 3;
  localparam int BIT_CRC_RESYNC_MET = 2;
  localparam int BIT_ALIGN_RESYNC_MET = 1;
  localparam int BIT_MF_RESYNC_MET = 0;
  localparam int CLOCK_FREQ_HZ = 20000000;
  localparam int CLOCK_LOST_NS = 2000;
  localparam int CLOCK_LOST_CYCLES =
    (CLOCK_LOST_NS * (CLOCK_FREQ_HZ / 1000000) + 999) / 1000;
  localparam int FAS_BAD_LIMIT = 3;
  localparam int MF_BAD_LIMIT = 2;
  localparam int CRC_WINDOW_WORDS = 1000;
  localparam int CRC_ERROR_LIMIT = 915;
endpackage : lsr_pkg

// ==== logic/lsr_framer_status.sv ====
// One framer's latched status registers, criteria counters and readable copies
`timescale 1ns/100ps
`default_nettype none
module lsr_framer_status
  import lsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Event sources
  input wire logic [7:0] ev_a_i,
  input wire logic [7:0] ev_b_i,
  input wire logic [7:0] info_raw_i,
  input wire logic rclk_sync_i,
  input wire logic crc_word_i,
  input wire logic crc_bad_i,
  input wire logic fas_word_i,
  input wire logic fas_bad_i,
  input wire logic mf_word_i,
  input wire logic mf_bad_i,
  // Host mask writes, one-hot register select
  input wire logic wr_i,
  input wire logic [2:0] wr_sel_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] mask_a_i,
  input wire logic [7:0] mask_b_i,
  // Readable copies and interrupt terms
  output logic [7:0] read_a_o,
  output logic [7:0] read_b_o,
  output logic [7:0] read_info_o,
  output logic irq_a_o,
  output logic irq_b_o
);
  // ==========================================================
  // Criteria counters
  logic [15:0] lost_cnt_q, lost_cnt_d;
  logic rclk_prev_q;
  logic [1:0] fas_run_q, fas_run_d, mf_run_q, mf_run_d;
  logic [9:0] crc_words_q, crc_words_d, crc_errs_q, crc_errs_d;
  logic [7:0] info_ev;
  logic clock_lost;

  always_comb
  begin
    lost_cnt_d = lost_cnt_q;
    clock_lost = 1'b0;
    if (rclk_sync_i != rclk_prev_q)
      lost_cnt_d = '0;
    else if (lost_cnt_q < 16'(CLOCK_LOST_CYCLES))
      lost_cnt_d = lost_cnt_q + 16'h0001;
    else
      clock_lost = 1'b1;
    fas_run_d = fas_run_q;
    if (fas_word_i)
      fas_run_d = fas_bad_i ? ((fas_run_q == 2'(FAS_BAD_LIMIT)) ?
                  fas_run_q : fas_run_q + 2'h1) : 2'h0;
    mf_run_d = mf_run_q;
    if (mf_word_i)
      mf_run_d = mf_bad_i ? ((mf_run_q == 2'(MF_BAD_LIMIT)) ?
                 mf_run_q : mf_run_q + 2'h1) : 2'h0;
    crc_words_d = crc_words_q;
    crc_errs_d = crc_errs_q;
    if (crc_word_i)
    begin
      if (crc_words_q == 10'(CRC_WINDOW_WORDS - 1))
      begin
        crc_words_d = '0;
        crc_errs_d = '0;
      end
      else
      begin
        crc_words_d = crc_words_q + 10'h001;
        crc_errs_d = crc_errs_q + {9'h000, crc_bad_i};
      end
    end
    info_ev = info_raw_i;
    info_ev[BIT_RX_CLOCK_LOST] = clock_lost;
    info_ev[BIT_CRC_RESYNC_MET] =
      (crc_errs_q >= 10'(CRC_ERROR_LIMIT));
    info_ev[BIT_ALIGN_RESYNC_MET] = (fas_run_q == 2'(FAS_BAD_LIMIT));
    info_ev[BIT_MF_RESYNC_MET] = (mf_run_q == 2'(MF_BAD_LIMIT));
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lost_cnt_q <= '0;
      rclk_prev_q <= 1'b0;
      fas_run_q <= '0;
      mf_run_q <= '0;
      crc_words_q <= '0;
      crc_errs_q <= '0;
    end
    else
    begin
      lost_cnt_q <= lost_cnt_d;
      rclk_prev_q <= rclk_sync_i;
      fas_run_q <= fas_run_d;
      mf_run_q <= mf_run_d;
      crc_words_q <= crc_words_d;
      crc_errs_q <= crc_errs_d;
    end
  end

  // ==========================================================
  // Latched bits and readable copies, one per register
  logic [7:0] src [3];
  logic [7:0] lat_q [3];
  logic [7:0] lat_d [3];
  logic [7:0] rd_q [3];
  logic [7:0] rd_d [3];
  assign src[0] = ev_a_i;
  assign src[1] = ev_b_i;
  assign src[2] = info_ev;

  for (genvar g = 0; g < 3; g++)
  begin : g_reg
    logic [7:0] wmask;
    always_comb
    begin
      wmask = (wr_i && wr_sel_i[g]) ? wr_data_i : 8'h00;
      // Copy takes the pre-clear value; unmasked bits hold
      rd_d[g] = (rd_q[g] & ~wmask) | (lat_q[g] & wmask);
      // Clear only masked bits; a new event the same cycle wins
      lat_d[g] = (lat_q[g] & ~wmask) | src[g];
    end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        lat_q[g] <= STATUS_RESET;
        rd_q[g] <= STATUS_RESET;
      end
      else
      begin
        lat_q[g] <= lat_d[g];
        rd_q[g] <= rd_d[g];
      end
    end
  end

  assign read_a_o = rd_q[0];
  assign read_b_o = rd_q[1];
  assign read_info_o = rd_q[2];
  // Only the two event registers reach the interrupt
  assign irq_a_o = |(lat_q[0] & mask_a_i);
  assign irq_b_o = |(lat_q[1] & mask_b_i);
endmodule : lsr_framer_status
`default_nettype wire

// ==== verif/lsr_status_monitor.sv ====
// Port checker for the four-framer status bank
`timescale 1ns/100ps
`default_nettype none
module lsr_status_monitor #(
  parameter int FRAMERS = 4
)
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Control port
  input wire logic [1:0] FRAMER_SEL_I,
  input wire logic [4:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  // Events and interrupt
  input wire logic [FRAMERS*8-1:0] EVENT_A_I,
  input wire logic [FRAMERS*8-1:0] EVENT_B_I,
  input wire logic [FRAMERS*8-1:0] SYNC_STATE_I,
  input wire logic INT_N_O
);
  import lsr_pkg::*;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  logic mapped;
  logic cause;
  assign mapped = ADDR_I inside {ADDR_EVENT_STATUS_A, ADDR_EVENT_STATUS_B,
    ADDR_RECEIVE_INFO, ADDR_EVENT_MASK_A, ADDR_EVENT_MASK_B,
    ADDR_SYNC_SEARCH, ADDR_IRQ_SUMMARY};
  assign cause = (|EVENT_A_I) || (|EVENT_B_I) || WR_I;
  // ==========================================
  // Read path and interrupt
  sequence s_sync_rd;
    RD_I && ADDR_I == ADDR_SYNC_SEARCH;
  endsequence
  sequence s_sum_rd;
    RD_I && ADDR_I == ADDR_IRQ_SUMMARY;
  endsequence
  sync_live_a: assert property (s_sync_rd |=> RDATA_O == 8'($past(
    SYNC_STATE_I) >> (8 * $past(FRAMER_SEL_I))))
    else $error("sync status read mismatch");
  unmapped_zero_a: assert property (RD_I && !mapped |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!RD_I |=> $stable(RDATA_O))
    else $error("read data moved without read");
  summary_int_a: assert property (s_sum_rd |=>
    INT_N_O == !(|RDATA_O))
    else $error("summary and interrupt disagree");
  int_cause_a: assert property ($fell(INT_N_O) |-> $past(cause) ||
    $past(cause, 2))
    else $error("interrupt without event or mask");
  int_release_a: assert property ($rose(INT_N_O) |-> $past(WR_I) ||
    $past(WR_I, 2))
    else $error("interrupt released without write");
  reset_int_a: assert property ($rose(RSTN_I) |-> INT_N_O)
    else $error("interrupt active after reset");
  reset_rdata_a: assert property ($rose(RSTN_I) |-> RDATA_O == 8'h00)
    else $error("read data not clear after reset");
endmodule : lsr_status_monitor
bind lsr_status_bank lsr_status_monitor #(.FRAMERS(FRAMERS)) i_mon (
  .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .FRAMER_SEL_I(FRAMER_SEL_I),
  .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .EVENT_A_I(EVENT_A_I), .EVENT_B_I(EVENT_B_I),
  .SYNC_STATE_I(SYNC_STATE_I), .INT_N_O(INT_N_O));
`default_nettype wire

// ==== verif/lsr_host_model.sv ====
// Host processor model on the parallel control port
`timescale 1ns/100ps
`default_nettype none
module lsr_host_model
(
  // Clock
  input wire logic clk_i,
  // Control port drive
  output logic [1:0] fsel_o,
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  // Read data back from the bank
  input wire logic [7:0] rdata_i
);
  initial
  begin
    fsel_o = 2'h0;
    addr_o = 5'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [1:0] f, input logic [4:0] a,
      input logic [7:0] d);
    @(negedge clk_i);
    fsel_o = f;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // Stale data must not look valid once the strobe is gone
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [1:0] f, input logic [4:0] a,
      output logic [7:0] d);
    @(negedge clk_i);
    fsel_o = f;
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
  task automatic poll(input logic [1:0] f, input logic [4:0] a,
      input logic [7:0] m, output logic [7:0] d);
    wr(f, a, m);
    rd(f, a, d);
    wr(f, a, d & m);
  endtask : poll
endmodule : lsr_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the four-framer status bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lsr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] fsel;
  logic [4:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [31:0] ev_a = '0;
  logic [31:0] ev_b = '0;
  logic [31:0] info = '0;
  logic [31:0] sync = '0;
  logic [3:0] rclk = '0;
  logic [3:0] fas_w = '0;
  logic [3:0] fas_b = '0;
  logic [3:0] mf_w = '0;
  logic [3:0] mf_b = '0;
  logic [3:0] crc_w = '0;
  logic [3:0] crc_b = '0;
  logic [2:0] rdiv = '0;
  logic int_n;
  logic rclk_run = 1'b0;
  int failures = 0;
  int n_compared = 0;
  lsr_status_bank i_dut (.REF_CLK_I(clk), .RSTN_I(rstn),
    .FRAMER_SEL_I(fsel), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
    .WDATA_I(wdata), .RDATA_O(rdata), .EVENT_A_I(ev_a), .EVENT_B_I(ev_b),
    .INFO_EVENT_I(info), .SYNC_STATE_I(sync), .RCLK_PIN_I(rclk),
    .CRC_WORD_I(crc_w), .CRC_BAD_I(crc_b), .FAS_WORD_I(fas_w),
    .FAS_BAD_I(fas_b), .MF_WORD_I(mf_w), .MF_BAD_I(mf_b), .INT_N_O(int_n));
  lsr_host_model i_host (.clk_i(clk), .fsel_o(fsel), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata));
  initial
  begin
    forever #25 clk = ~clk;
  end
  // Line clock slow enough that the three-flop filter sees each level
  always @(negedge clk)
    if (rclk_run)
    begin
      rdiv <= rdiv + 3'h1;
      if (rdiv == 3'h0)
        rclk[1] <= ~rclk[1];
    end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic poll(input logic [1:0] f, input logic [4:0] a,
      input logic [7:0] m, input logic [7:0] exp);
    i_host.poll(f, a, m, d);
    chk(d, exp);
  endtask : poll
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // ==========================================
  // Test sequence
  initial
  begin
    cyc(8);
    rstn = 1'b1;
    chk({7'h0, int_n}, 8'h01);
    i_host.rd(2'h0, 5'h00, d);
    chk(d, 8'h00);
    ev_a[10] = 1'b1;
    cyc(1);
    ev_a[10] = 1'b0;
    cyc(3);
    chk({7'h0, int_n}, 8'h01);
    i_host.wr(2'h1, ADDR_EVENT_MASK_A, 8'h04);
    cyc(3);
    chk({7'h0, int_n}, 8'h00);
    i_host.rd(2'h2, ADDR_IRQ_SUMMARY, d);
    chk(d, 8'h04);
    i_host.rd(2'h1, ADDR_EVENT_MASK_A, d);
    chk(d, 8'h04);
    poll(2'h1, ADDR_EVENT_STATUS_A, 8'h04, 8'h04);
    cyc(3);
    chk({7'h0, int_n}, 8'h01);
    poll(2'h1, ADDR_EVENT_STATUS_A, 8'h04, 8'h00);
    i_host.wr(2'h3, ADDR_EVENT_MASK_B, 8'h80);
    ev_b[31] = 1'b1;
    cyc(1);
    ev_b[31] = 1'b0;
    i_host.rd(2'h0, ADDR_IRQ_SUMMARY, d);
    chk(d, 8'h80);
    poll(2'h3, ADDR_EVENT_STATUS_B, 8'h80, 8'h80);
    ev_b[7:0] = 8'h81;
    cyc(1);
    ev_b[7:0] = 8'h00;
    // Mask write without write-back, so the copy keeps a one to hold
    i_host.wr(2'h0, ADDR_EVENT_STATUS_B, 8'h01);
    i_host.rd(2'h0, ADDR_EVENT_STATUS_B, d);
    chk(d, 8'h01);
    poll(2'h0, ADDR_EVENT_STATUS_B, 8'h00, 8'h01);
    poll(2'h0, ADDR_EVENT_STATUS_B, 8'h80, 8'h81);
    ev_a[16] = 1'b1;
    poll(2'h2, ADDR_EVENT_STATUS_A, 8'h01, 8'h01);
    poll(2'h2, ADDR_EVENT_STATUS_A, 8'h01, 8'h01);
    ev_a[16] = 1'b0;
    sync[31:24] = 8'h5a;
    i_host.rd(2'h3, ADDR_SYNC_SEARCH, d);
    chk(d, 8'h5a);
    sync[31:24] = 8'ha5;
    i_host.rd(2'h3, ADDR_SYNC_SEARCH, d);
    chk(d, 8'ha5);
    info[7:0] = 8'hff;
    cyc(1);
    info[7:0] = 8'h00;
    cyc(3);
    chk({7'h0, int_n}, 8'h01);
    poll(2'h0, ADDR_RECEIVE_INFO, 8'hd8, 8'hd8);
    for (int i = 0; i < 6; i++)
    begin
      fas_w[0] = 1'b1;
      fas_b[0] = (i != 2);
      mf_w[0] = 1'b1;
      mf_b[0] = (i > 3);
      cyc(1);
      fas_w[0] = 1'b0;
      mf_w[0] = 1'b0;
      cyc(1);
      if (i == 4)
        poll(2'h0, ADDR_RECEIVE_INFO, 8'h03, 8'h00);
    end
    poll(2'h0, ADDR_RECEIVE_INFO, 8'h03, 8'h03);
    rclk_run = 1'b1;
    cyc(10);
    poll(2'h1, ADDR_RECEIVE_INFO, 8'h20, 8'h20);
    poll(2'h1, ADDR_RECEIVE_INFO, 8'h20, 8'h00);
    rclk_run = 1'b0;
    cyc(CLOCK_LOST_CYCLES + 10);
    poll(2'h1, ADDR_RECEIVE_INFO, 8'h20, 8'h20);
    // One bad word short of the threshold, then the word that meets it
    crc_w[2] = 1'b1;
    crc_b[2] = 1'b1;
    cyc(CRC_ERROR_LIMIT - 1);
    crc_w[2] = 1'b0;
    poll(2'h2, ADDR_RECEIVE_INFO, 8'h04, 8'h00);
    crc_w[2] = 1'b1;
    cyc(1);
    crc_w[2] = 1'b0;
    poll(2'h2, ADDR_RECEIVE_INFO, 8'h04, 8'h04);
    end_sim();
  end
  // Whole sequence needs about 1,150 cycles, most of them CRC words
  initial
  begin
    cyc(5000);
    failures++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
